// ---- hdl/pmpp_cfg.svh ----
`ifndef PMPP_CFG_SVH
`define PMPP_CFG_SVH
// Wait-state step and timing
`define PMPP_WAIT_STEP_PS 6000
`define PMPP_MAX_WAIT 5'h1F
`define PMPP_MIN_WAIT 5'h01
`define PMPP_WAIT_RESET 5'h1F
// Bus geometry
`define PMPP_DATA_W 16
`define PMPP_ADDR_W 24
`define PMPP_NUM_CS 3
// Index of the wait fields inside a per-select timing word
`define PMPP_RD_LSB 0
`define PMPP_SU_LSB 5
`define PMPP_WP_LSB 10
`define PMPP_HD_LSB 15
`define PMPP_TIMING_W 20
`endif

// ---- hdl/pmpp_pkg.sv ----
package pmpp_pkg;
  typedef enum logic [2:0] {
    PMPP_IDLE = 3'b000,
    PMPP_READ = 3'b001,
    PMPP_WSETUP = 3'b010,
    PMPP_WPULSE = 3'b011,
    PMPP_WHOLD = 3'b100
  } pmpp_state_e;
  typedef logic [4:0] pmpp_wait_t;
endpackage

// ---- hdl/pmpp_port.sv ----
`include "pmpp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Three separate active-low chip select outputs
// - Boot flash on select zero, 16-bit data
// - Second select optional, port works unpopulated
// - Third select optional, independent of others
// - Optional extra top address bit pin
// - Wait states programmable up to 31
// - Each wait state adds one step
// - Read cycle held for read count
// - Write strobe delayed by setup count
// - Write strobe held low for pulse count
// - Select and data held for hold count
// - Zero count acts as one
// - Active-low strobe, data valid around rise
module pmpp_port #(
  parameter int DATA_W = `PMPP_DATA_W,
  parameter int ADDR_W = `PMPP_ADDR_W,
  parameter int NUM_CS = `PMPP_NUM_CS,
  parameter int STEP_DIV = 1
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [1:0] i_cs_sel,
  input wire logic [ADDR_W:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_extra_addr_en,
  input wire logic i_timing_we,
  input wire logic [1:0] i_timing_cs,
  input wire logic [`PMPP_TIMING_W-1:0] i_timing,
  input wire logic [DATA_W-1:0] i_data_in,
  output logic o_ready,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_boot_memory_select_n,
  output logic o_second_memory_select_n,
  output logic o_third_memory_select_n,
  output logic o_output_enable_n,
  output logic o_write_strobe_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_extra_addr,
  output logic o_extra_addr_oe_n,
  output logic [DATA_W-1:0] o_data_out,
  output logic o_data_oe_n
);

  // Zero setting is forced to one step
  function automatic pmpp_pkg::pmpp_wait_t min1(input pmpp_pkg::pmpp_wait_t v);
    min1 = (v == 5'h00) ? `PMPP_MIN_WAIT : v;
  endfunction

  pmpp_pkg::pmpp_state_e state_q, state_d;
  logic [`PMPP_TIMING_W-1:0] timing_q [NUM_CS];
  pmpp_pkg::pmpp_wait_t cnt_q, cnt_d;
  logic [$clog2(STEP_DIV+1)-1:0] div_q;
  logic step_en;
  logic [NUM_CS-1:0] cs_q;
  logic [1:0] cs_idx_q;
  logic we_q, oe_q, doe_q, done_q, xa_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q, rdata_q;
  logic [`PMPP_TIMING_W-1:0] cur_t;
  logic [`PMPP_TIMING_W-1:0] req_t;
  logic take;
  logic cnt_end;

  // Step enable, one pulse per wait-state step
  assign step_en = (div_q == STEP_DIV[$bits(div_q)-1:0] - 1'b1);
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || step_en)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  // Per-select timing words, written by firmware
  genvar g;
  generate
    for (g = 0; g < NUM_CS; g++)
    begin : g_tim
      always_ff @(posedge i_core_clk)
      begin
        if (i_srst)
          timing_q[g] <= {4{`PMPP_WAIT_RESET}};
        else if (i_timing_we && i_timing_cs == 2'(g))
          timing_q[g] <= i_timing;
      end
    end
  endgenerate

  // Selection and handshake
  assign cur_t = timing_q[cs_idx_q];
  assign req_t = timing_q[i_cs_sel];
  assign take = i_req && (state_q == pmpp_pkg::PMPP_IDLE)
                && (i_cs_sel < NUM_CS[1:0]);
  assign o_ready = (state_q == pmpp_pkg::PMPP_IDLE);
  assign cnt_end = step_en && (cnt_q == 5'h01);

  // Next state and wait counter
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (step_en && cnt_q > 5'h01)
      cnt_d = cnt_q - 5'h01;
    case (state_q)
      pmpp_pkg::PMPP_IDLE:
      begin
        if (take && i_write)
        begin
          state_d = pmpp_pkg::PMPP_WSETUP;
          cnt_d = min1(req_t[`PMPP_SU_LSB +: 5]);
        end
        else if (take)
        begin
          state_d = pmpp_pkg::PMPP_READ;
          cnt_d = min1(req_t[`PMPP_RD_LSB +: 5]);
        end
      end
      pmpp_pkg::PMPP_READ:
        if (cnt_end)
          state_d = pmpp_pkg::PMPP_IDLE;
      pmpp_pkg::PMPP_WSETUP:
        if (cnt_end)
        begin
          state_d = pmpp_pkg::PMPP_WPULSE;
          cnt_d = min1(cur_t[`PMPP_WP_LSB +: 5]);
        end
      pmpp_pkg::PMPP_WPULSE:
        if (cnt_end)
        begin
          state_d = pmpp_pkg::PMPP_WHOLD;
          cnt_d = min1(cur_t[`PMPP_HD_LSB +: 5]);
        end
      pmpp_pkg::PMPP_WHOLD:
        if (cnt_end)
          state_d = pmpp_pkg::PMPP_IDLE;
      default:
        state_d = pmpp_pkg::PMPP_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      state_q <= pmpp_pkg::PMPP_IDLE;
      cnt_q <= 5'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Request capture: address, data and select
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      addr_q <= '0;
      wdata_q <= '0;
      xa_q <= 1'b0;
      cs_idx_q <= 2'h0;
    end
    else if (take)
    begin
      addr_q <= i_addr[ADDR_W-1:0];
      xa_q <= i_addr[ADDR_W] && i_extra_addr_en;
      wdata_q <= i_wdata;
      cs_idx_q <= i_cs_sel;
    end
  end

  // Pin control: selects, strobes and data drive
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      cs_q <= '0;
      oe_q <= 1'b0;
      we_q <= 1'b0;
      doe_q <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < NUM_CS; k++)
        cs_q[k] <= (state_d != pmpp_pkg::PMPP_IDLE)
                   && ((take ? i_cs_sel : cs_idx_q) == k[1:0]);
      oe_q <= (state_d == pmpp_pkg::PMPP_READ);
      we_q <= (state_d == pmpp_pkg::PMPP_WPULSE);
      doe_q <= (state_d == pmpp_pkg::PMPP_WSETUP)
               || (state_d == pmpp_pkg::PMPP_WPULSE)
               || (state_d == pmpp_pkg::PMPP_WHOLD);
    end
  end

  // Read data captured at end of read window
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      rdata_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= cnt_end && (state_q == pmpp_pkg::PMPP_READ
                            || state_q == pmpp_pkg::PMPP_WHOLD);
      if (cnt_end && state_q == pmpp_pkg::PMPP_READ)
        rdata_q <= i_data_in;
    end
  end

  // Output pins; unused selects stay high
  assign o_boot_memory_select_n = ~cs_q[0];
  assign o_second_memory_select_n = ~cs_q[1];
  assign o_third_memory_select_n = ~cs_q[2];
  assign o_output_enable_n = ~oe_q;
  assign o_write_strobe_n = ~we_q;
  assign o_addr = addr_q;
  assign o_extra_addr = xa_q;
  assign o_extra_addr_oe_n = ~i_extra_addr_en;
  assign o_data_out = wdata_q;
  assign o_data_oe_n = ~doe_q;
  assign o_rdata = rdata_q;
  assign o_done = done_q;

endmodule
`default_nettype wire

// ---- bench/pmpp_flash.sv ----
`timescale 1ns/1ps
`default_nettype none
// Asynchronous NOR flash model on the boot select
module pmpp_flash (
  input wire logic i_clk,
  input wire logic i_sel_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata
);
  logic [15:0] mem_q [16];
  logic [15:0] last_q = 16'h0000;
  logic drive;
  // Word written on strobe rise
  always @(posedge i_we_n)
    if (!i_sel_n)
      mem_q[i_addr[3:0]] = i_wdata;
  // Drives when read-selected, else inverse of last word
  assign drive = !i_sel_n && !i_oe_n;
  assign o_rdata = drive ? mem_q[i_addr[3:0]] : ~last_q;
  always @(posedge i_clk)
    if (drive)
      last_q <= o_rdata;
endmodule
`default_nettype wire

// ---- bench/pmpp_port_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// Select and strobe checks at the port pins
module pmpp_checker #(
  parameter int ADDR_W = 24
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [1:0] i_cs_sel,
  input wire logic [ADDR_W:0] i_addr,
  input wire logic i_extra_addr_en,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_boot_memory_select_n,
  input wire logic o_second_memory_select_n,
  input wire logic o_third_memory_select_n,
  input wire logic o_output_enable_n,
  input wire logic o_write_strobe_n,
  input wire logic o_extra_addr,
  input wire logic o_extra_addr_oe_n,
  input wire logic o_data_oe_n
);
  logic [2:0] sel;
  // Active selects, one bit each
  assign sel = ~{o_third_memory_select_n, o_second_memory_select_n,
    o_boot_memory_select_n};
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  sequence s_wtake;
    o_ready && i_req && i_write && i_cs_sel != 2'h3;
  endsequence
  chk_one_select: assert property ($onehot0(sel))
    else $error("two selects low");
  chk_idle_free: assert property (o_ready |-> sel == 3'h0)
    else $error("select low while idle");
  chk_bad_select: assert property (
    o_ready && i_req && i_cs_sel == 2'h3 |=> o_ready)
    else $error("select three taken");
  chk_write_setup: assert property (
    s_wtake |=> o_write_strobe_n && !o_data_oe_n && sel != 3'h0)
    else $error("strobe without setup");
  chk_strobe_hold: assert property (
    $rose(o_write_strobe_n) |-> sel != 3'h0 && !o_data_oe_n)
    else $error("select or data dropped at strobe rise");
  chk_no_contend: assert property (
    !(!o_output_enable_n && !o_write_strobe_n))
    else $error("read and write enables both low");
  chk_done_single: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  chk_extra_pin: assert property (
    o_ready && i_req && i_cs_sel != 2'h3 && i_extra_addr_en |=>
    o_extra_addr == $past(i_addr[ADDR_W]) && !o_extra_addr_oe_n)
    else $error("extra address pin wrong");
endmodule
bind pmpp_port pmpp_checker #(.ADDR_W(ADDR_W)) i_chk (.*);
`default_nettype wire

// ---- bench/tb_program_memory_parallel_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_program_memory_parallel_port;
  logic i_core_clk = 1'b0, i_srst = 1'b1, i_req = 1'b0, i_write = 1'b0;
  logic i_extra_addr_en = 1'b0, i_timing_we = 1'b0;
  logic [1:0] i_cs_sel = 2'h0, i_timing_cs = 2'h0;
  logic [24:0] i_addr = 25'h000_0000;
  logic [15:0] i_wdata = 16'h0000, i_data_in, o_rdata, o_data_out;
  logic [19:0] i_timing = 20'h0_0000;
  logic o_ready, o_done, o_boot_memory_select_n, o_second_memory_select_n;
  logic o_third_memory_select_n, o_output_enable_n, o_write_strobe_n;
  logic o_extra_addr, o_extra_addr_oe_n, o_data_oe_n;
  logic [23:0] o_addr;
  int fail_count = 0, tests_run = 0, cyc = 0, n, p;
  pmpp_port i_dut (.*);
  pmpp_flash i_mem (.i_clk(i_core_clk), .i_sel_n(o_boot_memory_select_n),
    .i_oe_n(o_output_enable_n), .i_we_n(o_write_strobe_n),
    .i_addr(o_addr), .i_wdata(o_data_out), .o_rdata(i_data_in));
  // Clock and hang guard
  always #20 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic set_t(input logic [1:0] cs, input logic [19:0] t);
    @(posedge i_core_clk);
    {i_timing_cs, i_timing, i_timing_we} <= {cs, t, 1'b1};
    @(posedge i_core_clk);
    i_timing_we <= 1'b0;
  endtask
  // One access; n counts cycles to done, p strobe-low cycles
  task automatic acc(input logic w, input logic [1:0] cs,
    input logic [24:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    {i_write, i_cs_sel, i_addr, i_wdata, i_req} <= {w, cs, a, d, 1'b1};
    @(posedge i_core_clk);
    i_req <= 1'b0;
    n = 0;
    p = 0;
    while (o_done !== 1'b1 && n < 100)
    begin
      @(posedge i_core_clk);
      #1;
      n++;
      p += int'(o_write_strobe_n === 1'b0);
    end
  endtask
  task automatic t_read();
    logic [4:0] r [4] = '{5'h00, 5'h01, 5'h02, 5'h1F};
    for (int k = 0; k < 4; k++)
    begin
      set_t(2'h0, {15'h0000, r[k]});
      acc(1'b1, 2'h0, 25'(k), 16'hC3A0 + 16'(k));
      chk("wr min", 3, n);
      acc(1'b0, 2'h0, 25'(k), 16'h0000);
      chk("rd cycles", (r[k] == 5'h00) ? 1 : r[k], n);
      chk("rd data", 16'hC3A0 + 16'(k), o_rdata);
    end
    $display("read wait test done");
  endtask
  task automatic t_write();
    set_t(2'h0, {5'h01, 5'h03, 5'h02, 5'h00});
    acc(1'b1, 2'h0, 25'h000_0009, 16'h5A5A);
    chk("wr cycles", 6, n);
    chk("wr pulse", 3, p);
    $display("write wait test done");
  endtask
  task automatic t_sel();
    set_t(2'h1, 20'h0_0005);
    set_t(2'h2, 20'h0_0003);
    acc(1'b0, 2'h1, 25'h000_0001, 16'h0000);
    chk("second rd", 5, n);
    acc(1'b0, 2'h2, 25'h000_0001, 16'h0000);
    chk("third rd", 3, n);
    acc(1'b0, 2'h3, 25'h000_0001, 16'h0000);
    chk("no select", 100, n);
    @(posedge i_core_clk);
    i_extra_addr_en <= 1'b1;
    acc(1'b0, 2'h0, 25'h100_0002, 16'h0000);
    chk("boot rd kept", 1, n);
    chk("extra oe", 0, o_extra_addr_oe_n);
    chk("extra bit", 1, o_extra_addr);
    chk("extra rd", 16'hC3A2, o_rdata);
    $display("select test done");
  endtask
  initial
  begin
    repeat (10) @(posedge i_core_clk);
    i_srst <= 1'b0;
    #1;
    chk("idle sel", 3'h7, {o_boot_memory_select_n,
      o_second_memory_select_n, o_third_memory_select_n});
    chk("idle ready", 1, o_ready);
    t_read();
    t_write();
    t_sel();
    give_verdict();
  end
endmodule
`default_nettype wire
